// [verilog/timestamped_digital_io.sv]
// 32-channel digital port with edge monitor, spike filter and timed output
// How it works
// - Variant A: every channel has its own direction bit.
// - Variant B: one direction bit per group of 8 channels.
// - After reset all channels are inputs; nothing is driven.
// - Variant A: monitor timestamps advance at the 100 MHz rate.
// - Every filtered input change pushes levels plus timestamp into the FIFO.
// - Variant A: FIFO holds 511 pairs; software pops them by reading.
// - Variant B: timestamps count in 200 MHz steps.
// - Variant B: FIFO holds 2048 pairs.
// - Rising and falling edges are latched per channel for software to read.
// - Every input has its own spike filter sharing one length setting.
// - Filters are off after reset; inputs pass straight through.
// - The FIFO serves monitoring or timed output, never both at once.
// - Timed output pops pattern/time pairs and drives each when due.
// - Variant B: 2048 output pairs, time points in 5 ns steps.
// - Variant B: voltage level code selectable per group of 8 channels.
// - If a boot program is present, the sequencer starts after reset.
// - The sequencer sees all inputs and may drive all outputs.
// - Sequencer rate is 50 MHz in variant A, 100 MHz in variant B.
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsdio_regs.svh"

module timestamped_digital_io #(
    parameter bit VARIANT_B = 1'b0,
    parameter int DEPTH     = `DEPTH_A
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] io_in,
    output logic [31:0]      io_out,
    output logic [31:0]      io_oe,
    output logic [31:0]      io_level,
    input  wire logic        boot_present,
    output logic             seq_run,
    output logic [7:0]       seq_clk_mhz,
    input  wire logic        seq_drive_en,
    input  wire logic [31:0] seq_dout,
    output logic [31:0]      seq_din
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [31:0] TICKS = VARIANT_B ? 32'(`TICKS_B) : 32'(`TICKS_A);

    // ==========================================
    // Register state
    logic [1:0]  ctrl_reg, ctrl_next;
    logic [31:0] dir_reg, dir_next;
    logic [7:0]  filt_reg, filt_next;
    logic [31:0] level_reg, level_next;
    logic [31:0] dout_reg, dout_next;
    logic [31:0] pat_reg, pat_next;
    logic [31:0] rise_reg, rise_next;
    logic [31:0] fall_reg, fall_next;
    logic [31:0] ts_reg, ts_next;
    logic        mode_out, fifo_en;

    // AXI holding state
    logic [7:0]  aw_addr_reg, aw_addr_next;
    logic        aw_v_reg, aw_v_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0]  w_strb_reg, w_strb_next;
    logic        w_v_reg, w_v_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic        wr_fire, rd_fire;
    logic [31:0] wmask;

    // FIFO and timed output
    tsdio_pkg::pair_t mem [DEPTH];
    tsdio_pkg::pair_t head, push_data;
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic          full, empty, push, pop, push_mon, push_sw, pop_rd, pop_out;
    logic          clr_cmd, start_cmd, due;
    tsdio_pkg::out_state_t st_reg, st_next;
    logic [31:0]   opat_reg, opat_next;
    logic [31:0]   io_out_reg, io_out_next;

    // Inputs, filter, edges, sequencer
    logic [31:0] filt_q, prev_reg, chg, new_rise, new_fall;
    logic        seq_run_reg, seq_run_next, boot_done_reg;

    assign mode_out = ctrl_reg[`CTRL_MODE];
    assign fifo_en  = ctrl_reg[`CTRL_FIFO_EN];

    // ==========================================
    // AXI4-Lite slave: address and data taken in either order
    assign s_axi_awready = !aw_v_reg;
    assign s_axi_wready  = !w_v_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign wr_fire = aw_v_reg && w_v_reg && !bvalid_reg;
    assign rd_fire = s_axi_arvalid && !rvalid_reg;
    assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // Write/read side effects that feed other groups
    assign clr_cmd   = wr_fire && aw_addr_reg == `A_CTRL && wmask[`CTRL_CLEAR] && w_data_reg[`CTRL_CLEAR];
    assign start_cmd = wr_fire && aw_addr_reg == `A_CTRL && wmask[`CTRL_START] && w_data_reg[`CTRL_START];
    // Time word completes a pair; only accepted in output mode
    assign push_sw = wr_fire && aw_addr_reg == `A_TIME && mode_out && !full;
    // Reading the time word pops a monitor entry; level word must be read first
    assign pop_rd  = rd_fire && s_axi_araddr == `A_TIME && !mode_out && !empty;

    // Next state of the bus channels and registers
    always_comb begin
        aw_addr_next = aw_addr_reg;
        aw_v_next    = aw_v_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        w_v_next     = w_v_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        ctrl_next    = ctrl_reg;
        dir_next     = dir_reg;
        filt_next    = filt_reg;
        level_next   = level_reg;
        dout_next    = dout_reg;
        pat_next     = pat_reg;
        if (s_axi_awvalid && !aw_v_reg) begin
            aw_addr_next = s_axi_awaddr;
            aw_v_next    = 1'b1;
        end
        if (s_axi_wvalid && !w_v_reg) begin
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
            w_v_next    = 1'b1;
        end
        if (wr_fire) begin
            aw_v_next   = 1'b0;
            w_v_next    = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = 2'h0;
            case (aw_addr_reg)
                `A_CTRL:  ctrl_next = (ctrl_reg & ~wmask[1:0]) | (w_data_reg[1:0] & wmask[1:0]);
                `A_DIR:   dir_next = (dir_reg & ~wmask) | (w_data_reg & wmask);
                `A_FILT:  filt_next = (filt_reg & ~wmask[7:0]) | (w_data_reg[7:0] & wmask[7:0]);
                `A_LEVEL: level_next = (level_reg & ~wmask) | (w_data_reg & wmask);
                `A_DOUT:  dout_next = (dout_reg & ~wmask) | (w_data_reg & wmask);
                `A_PAT:   pat_next = (pat_reg & ~wmask) | (w_data_reg & wmask);
                `A_TIME, `A_DIN, `A_RISE, `A_FALL, `A_STATUS, `A_TIMER: bresp_next = 2'h0;
                default:  bresp_next = 2'h2;
            endcase
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next  = 2'h0;
            case (s_axi_araddr)
                `A_CTRL:   rdata_next = {30'h0, ctrl_reg};
                `A_DIR:    rdata_next = dir_reg;
                `A_FILT:   rdata_next = {24'h0, filt_reg};
                `A_LEVEL:  rdata_next = level_reg;
                `A_DOUT:   rdata_next = dout_reg;
                `A_DIN:    rdata_next = filt_q;
                `A_RISE:   rdata_next = rise_reg;
                `A_FALL:   rdata_next = fall_reg;
                `A_STATUS: rdata_next = 32'({cnt_reg, 4'h0, seq_run_reg, st_reg == tsdio_pkg::OUT_RUN,
                                             empty, full});
                `A_PAT:    rdata_next = head.level;
                `A_TIME:   rdata_next = head.ts;
                `A_TIMER:  rdata_next = ts_reg;
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = 2'h2;
                end
            endcase
        end
    end

    // Register the bus and software state; all inputs, filters off at reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr_reg <= 8'h00;
            aw_v_reg    <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            w_v_reg     <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= 2'h0;
            ctrl_reg    <= `CTRL_RST;
            dir_reg     <= `DIR_RST;
            filt_reg    <= `FILT_RST;
            level_reg   <= `LEVEL_RST;
            dout_reg    <= `DOUT_RST;
            pat_reg     <= 32'h00000000;
        end else begin
            aw_addr_reg <= aw_addr_next;
            aw_v_reg    <= aw_v_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            w_v_reg     <= w_v_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            ctrl_reg    <= ctrl_next;
            dir_reg     <= dir_next;
            filt_reg    <= filt_next;
            level_reg   <= level_next;
            dout_reg    <= dout_next;
            pat_reg     <= pat_next;
        end
    end

    // ==========================================
    // Direction and voltage level per channel or per group
    genvar g;
    generate
        for (g = 0; g < 32 / `GROUP_W; g++) begin : grp
            // Variant B uses only the low bit of each group's direction byte; the level byte is used whole
            assign io_oe[g*`GROUP_W +: `GROUP_W] = VARIANT_B ? {`GROUP_W{dir_reg[g*`GROUP_W]}}
                                                             : dir_reg[g*`GROUP_W +: `GROUP_W];
            assign io_level[g*`GROUP_W +: `GROUP_W] = VARIANT_B ? level_reg[g*`GROUP_W +: `GROUP_W]
                                                                : 8'h00;
        end
    endgenerate

    // ==========================================
    // Spike filter: change accepted after a stable run of filt_reg cycles
    generate
        for (g = 0; g < 32; g++) begin : flt
            logic [7:0] run_reg, run_next;
            logic       q_reg, q_next;
            always_comb begin
                run_next = 8'h00;
                q_next   = q_reg;
                if (filt_reg == 8'h00) begin
                    q_next = io_in[g];
                end else if (io_in[g] != q_reg) begin
                    run_next = run_reg + 8'h01;
                    if (run_next >= filt_reg) begin
                        q_next   = io_in[g];
                        run_next = 8'h00;
                    end
                end
            end
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    run_reg <= 8'h00;
                    q_reg   <= 1'b0;
                end else begin
                    run_reg <= run_next;
                    q_reg   <= q_next;
                end
            end
            assign filt_q[g] = q_reg;
        end
    endgenerate

    // ==========================================
    // Edge latches and timestamp counter
    assign chg      = filt_q ^ prev_reg;
    assign new_rise = chg & filt_q;
    assign new_fall = chg & ~filt_q;
    assign seq_din  = filt_q;

    // A read clears only what was shown; a new edge in that cycle still sets
    always_comb begin
        rise_next = rise_reg;
        fall_next = fall_reg;
        if (rd_fire && s_axi_araddr == `A_RISE) begin
            rise_next = 32'h00000000;
        end
        if (rd_fire && s_axi_araddr == `A_FALL) begin
            fall_next = 32'h00000000;
        end
        rise_next = rise_next | new_rise;
        fall_next = fall_next | new_fall;
        // Timestamp advances in monitor ticks per system cycle
        ts_next = ts_reg + TICKS;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 32'h00000000;
            rise_reg <= 32'h00000000;
            fall_reg <= 32'h00000000;
            ts_reg   <= 32'h00000000;
        end else begin
            prev_reg <= filt_q;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
            ts_reg   <= ts_next;
        end
    end

    // ==========================================
    // FIFO shared by the monitor and the timed output
    assign full  = cnt_reg == CW'(DEPTH);
    assign empty = cnt_reg == '0;
    assign head  = mem[rp_reg];
    assign push_mon = !mode_out && fifo_en && (chg != 32'h00000000) && !full;
    assign push  = push_mon || push_sw;
    // Wrap-safe compare: due once the timer has reached the time point
    assign due   = !ts_reg[31] ? $signed(ts_reg - head.ts) >= 0 : $signed(ts_reg - head.ts) >= 0;
    assign pop_out = st_reg == tsdio_pkg::OUT_RUN && !empty && due;
    assign pop   = pop_rd || pop_out;
    assign push_data.level = push_mon ? filt_q : pat_reg;
    assign push_data.ts    = push_mon ? ts_reg : w_data_reg;

    always_comb begin
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (clr_cmd) begin
            wp_next  = '0;
            rp_next  = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + AW'(1);
            end
            if (pop) begin
                rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + AW'(1);
            end
            cnt_next = cnt_reg + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; the pointers guard stale words
    always_ff @(posedge clk_sys) begin
        if (push && !clr_cmd) begin
            mem[wp_reg] <= push_data;
        end
    end

    // ==========================================
    // Timed output sequencer and pin drive
    always_comb begin
        st_next     = st_reg;
        opat_next   = opat_reg;
        case (st_reg)
            tsdio_pkg::OUT_IDLE: begin
                opat_next = dout_reg; // Run opens on the software level, not a stale pattern
                // Start is honoured only once output mode is enabled
                if (start_cmd && mode_out && fifo_en) begin
                    st_next = tsdio_pkg::OUT_RUN;
                end
            end
            tsdio_pkg::OUT_RUN: begin
                if (pop_out) begin
                    opat_next = head.level;
                end
                if (!mode_out || !fifo_en || clr_cmd) begin
                    st_next = tsdio_pkg::OUT_IDLE;
                end
            end
            default: st_next = tsdio_pkg::OUT_IDLE;
        endcase
        // Sequencer wins over the timed pattern, which wins over software
        if (seq_drive_en) begin
            io_out_next = seq_dout;
        end else if (st_reg == tsdio_pkg::OUT_RUN) begin
            io_out_next = opat_reg;
        end else begin
            io_out_next = dout_reg;
        end
        seq_run_next = boot_done_reg ? seq_run_reg : boot_present;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg        <= tsdio_pkg::OUT_IDLE;
            opat_reg      <= 32'h00000000;
            io_out_reg    <= 32'h00000000;
            seq_run_reg   <= 1'b0;
            boot_done_reg <= 1'b0;
        end else begin
            st_reg        <= st_next;
            opat_reg      <= opat_next;
            io_out_reg    <= io_out_next;
            seq_run_reg   <= seq_run_next;
            boot_done_reg <= 1'b1;
        end
    end

    assign io_out      = io_out_reg;
    assign seq_run     = seq_run_reg;
    assign seq_clk_mhz = VARIANT_B ? 8'(`SEQ_MHZ_B) : 8'(`SEQ_MHZ_A);

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    dir_reset_a: assert property ($rose(rst_n) |-> io_oe == 32'h00000000)
        else $error("channels not inputs after reset");
    mon_push_a: assert property (push_mon && !pop && !clr_cmd |=> cnt_reg == $past(cnt_reg) + CW'(1))
        else $error("monitor change not stored");
    full_hold_a: assert property (full |-> !push)
        else $error("push into full FIFO");
    mode_excl_a: assert property (mode_out |-> !push_mon)
        else $error("monitor push in output mode");
    edge_set_a: assert property (new_rise != 32'h0 |=> (rise_reg & $past(new_rise)) == $past(new_rise))
        else $error("rising edge lost");
    filt_off_a: assert property (filt_reg == 8'h00 |=> filt_q == $past(io_in))
        else $error("disabled filter delayed input");
    timed_out_a: assert property (pop_out && !seq_drive_en ##1 !seq_drive_en
                                  |=> io_out == $past(head.level, 2))
        else $error("due pattern not driven");
    boot_run_a: assert property (!boot_done_reg |=> seq_run == $past(boot_present))
        else $error("boot start wrong");
    clear_a: assert property (clr_cmd |=> empty && !full)
        else $error("clear left entries");
    bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    mon_fill_c: cover property (push_mon ##[1:20] pop_rd);
    timed_c: cover property (start_cmd ##[1:200] pop_out);
    full_c: cover property (full);
endmodule
`default_nettype wire

// [verilog/tsdio_regs.svh]
// Register offsets, field positions, reset values and timing counts of the digital port
`ifndef TSDIO_REGS_SVH
`define TSDIO_REGS_SVH
// ==========================================
// Register byte offsets
`define A_CTRL    8'h00
`define A_DIR     8'h04
`define A_FILT    8'h08
`define A_LEVEL   8'h0C
`define A_DOUT    8'h10
`define A_DIN     8'h14
`define A_RISE    8'h18
`define A_FALL    8'h1C
`define A_STATUS  8'h20
`define A_PAT     8'h24
`define A_TIME    8'h28
`define A_TIMER   8'h2C
// ==========================================
// Control and status fields
`define CTRL_FIFO_EN 0
`define CTRL_MODE    1
`define CTRL_CLEAR   2
`define CTRL_START   3
`define ST_FULL      0
`define ST_EMPTY     1
`define ST_RUN       2
`define ST_SEQ       3
`define ST_CNT_LSB   8
// ==========================================
// Reset values
`define CTRL_RST  2'h0
`define DIR_RST   32'h00000000
`define FILT_RST  8'h00
`define LEVEL_RST 32'h00000000
`define DOUT_RST  32'h00000000
// ==========================================
// Rates and derived counts
`define CLK_NS      40
`define MON_MHZ_A   100
`define MON_MHZ_B   200
`define SEQ_MHZ_A   50
`define SEQ_MHZ_B   100
`define TICKS_A     ((`MON_MHZ_A * `CLK_NS) / 1000)
`define TICKS_B     ((`MON_MHZ_B * `CLK_NS) / 1000)
`define DEPTH_A     511
`define DEPTH_B     2048
`define GROUP_W     8
`endif

// [verilog/tsdio_pkg.sv]
// Types shared by the timestamped digital port
package tsdio_pkg;
    // ==========================================
    // One FIFO entry: levels and time point
    typedef struct packed {
        logic [31:0] level;
        logic [31:0] ts;
    } pair_t;

    // ==========================================
    // Timed output sequencer states
    typedef enum logic [1:0] {
        OUT_IDLE = 2'b01,
        OUT_RUN  = 2'b10
    } out_state_t;
endpackage

// [dv/cpu_bus_model.sv]
// Backplane CPU model: AXI4-Lite master with one write and one read task
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input  wire logic        clk_sys,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // Idle bus at time zero
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    initial {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    // ==========================================
    // Write: both channels offered, each dropped when taken; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    // ==========================================
    // Read: rready held until rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

// [dv/timestamped_digital_io_bench.sv]
// Self-checking bench of the timestamped digital port, variant A
`timescale 1ns/1ps
`default_nettype none
`include "tsdio_regs.svh"
module timestamped_digital_io_bench;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, seq_clk_mhz;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, seq_run;
    logic [31:0] s_axi_wdata, s_axi_rdata, io_out, io_oe, io_level, seq_din, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] io_in = 32'h0;
    logic [31:0] seq_dout = 32'h0;
    logic        boot_present = 1'b1;
    logic        seq_drive_en = 1'b0;
    int          bad_count = 0;
    int          checks = 0;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
    row_t rows[3] = '{'{`A_DIR, 32'hA5A50F0F, 32'hA5A50F0F}, '{`A_FILT, 32'h000001FF, 32'h000000FF},
                      '{`A_DOUT, 32'h12345678, 32'h12345678}};
    always #20 clk_sys = ~clk_sys;
    timestamped_digital_io #(.VARIANT_B(1'b0), .DEPTH(`DEPTH_A)) DUT (.*);
    cpu_bus_model BUS (.*);
    // ==========================================
    // Compare, read-and-compare, verdict
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        BUS.rd(a, d, r);
        chk(n, d, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, more than ten times the expected run length
    initial begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("io_oe", io_oe, 32'h0);
        chk("seq_run", {31'h0, seq_run}, 32'h1);
        chk("seq_clk", {24'h0, seq_clk_mhz}, 32'h32);
        chk("io_level", io_level, 32'h0);
        rdc("dir", `A_DIR, 32'h0);
        rdc("filt", `A_FILT, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            BUS.wr(rows[i].a, rows[i].d, resp);
            rdc("reg", rows[i].a, rows[i].e);
        end
        chk("io_oe", io_oe, 32'hA5A50F0F);
        BUS.wr(8'hFC, 32'h1, resp);
        chk("bresp", {30'h0, resp}, 32'h2);
        BUS.rd(8'hFC, v, resp);
        chk("unmapped", v, 32'h0);
        chk("rresp", {30'h0, resp}, 32'h2);
        $display("test registers done");
        // Filter off first: the row loop left the longest length set
        BUS.wr(`A_FILT, 32'h0, resp);
        // Sequencer takes over the pins, then the monitor records edges
        seq_drive_en <= 1'b1;
        seq_dout     <= 32'hC3C3C3C3;
        io_in        <= 32'h00000F00;
        repeat (4) @(posedge clk_sys);
        chk("seq_out", io_out, 32'hC3C3C3C3);
        chk("seq_din", seq_din, 32'h00000F00);
        seq_drive_en <= 1'b0;
        rdc("rise", `A_RISE, 32'h00000F00);
        BUS.wr(`A_CTRL, 32'h1, resp);
        io_in <= 32'h00000001;
        repeat (6) @(posedge clk_sys);
        BUS.rd(`A_STATUS, v, resp);
        chk("count", {23'h0, v[16:8]}, 32'h1);
        rdc("pat", `A_PAT, 32'h1);
        rdc("fall", `A_FALL, 32'h00000F00);
        rdc("rise0", `A_RISE, 32'h1);
        BUS.rd(`A_TIME, v, resp);
        BUS.rd(`A_STATUS, v, resp);
        chk("popped", {23'h0, v[16:8]}, 32'h0);
        // A two-cycle spike must not pass a four-cycle filter
        BUS.wr(`A_FILT, 32'h4, resp);
        io_in <= 32'h00000003;
        repeat (2) @(posedge clk_sys);
        io_in <= 32'h00000001;
        repeat (10) @(posedge clk_sys);
        rdc("spike", `A_RISE, 32'h0);
        $display("test monitor done");
        // Enable output mode and fill before start
        BUS.wr(`A_CTRL, 32'h3, resp);
        BUS.wr(`A_DIR, 32'hFFFFFFFF, resp);
        BUS.rd(`A_TIMER, v, resp);
        BUS.wr(`A_PAT, 32'h0000005A, resp);
        BUS.wr(`A_TIME, v + 32'h190, resp);
        BUS.rd(`A_STATUS, v, resp);
        chk("not_empty", {31'h0, v[`ST_EMPTY]}, 32'h0);
        BUS.wr(`A_CTRL, 32'hB, resp);
        chk("early", io_out, 32'h12345678);
        for (int k = 0; k < 200 && io_out !== 32'h5A; k++) @(posedge clk_sys);
        chk("timed", io_out, 32'h0000005A);
        rdc("status", `A_STATUS, 32'h0000000E);
        BUS.rd(`A_STATUS, v, resp);
        chk("empty", {31'h0, v[`ST_EMPTY]}, 32'h1);
        // A far-future pair must vanish on clear, which also stops the run
        BUS.wr(`A_TIME, 32'h40000000, resp);
        BUS.wr(`A_CTRL, 32'h7, resp);
        rdc("cleared", `A_STATUS, 32'h0000000A);
        $display("test timed output done");
        wrap_up();
    end
endmodule
`default_nettype wire
